// [shared/rmu_pkg.sv]
package rmu_pkg;
   localparam logic [6:0] OPC_MUL_FILE = 7'h01;
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 9;
   localparam int SEL_BIT = 8;
   localparam logic [7:0] IDX_MAX = 8'h5f;
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_HI_BANK = 4'hf;
   localparam logic [7:0] PROD_RST = 8'h00;
   localparam int CLK_NS = 100;
   localparam int PHASES = 4;

   typedef enum logic [1:0] {RMU_ADDR_ACCESS, RMU_ADDR_BANKED, RMU_ADDR_INDEXED} rmu_mode_t;

   typedef struct packed {
      logic [11:0] addr;
      logic rd;
      rmu_mode_t mode;
   } rmu_mem_req_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } rmu_prod_t;
endpackage

// [rtl/rmu_core.sv]
// How it works
// RQ1: Opcode 0000001a ffffffff is decoded; accumulator times operand, unsigned.
// RQ2: Product bits 15..8 go to product_high_byte, 7..0 to product_low_byte.
// RQ3: Accumulator and operand are never written; only product pair changes.
// RQ4: No status flag output is driven by this operation; zero not detected.
// RQ5: Selector 0 addresses the fast access bank.
// RQ6: Selector 1 combines bank_select_register with the file address.
// RQ7: Selector 0, extended set, address <= 95 uses indexed literal offset.
// RQ8: One cycle: decode Q1, read Q2, multiply Q3, write pair Q4.
module rmu_core (
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic [1:0] PHASE_I,
   input wire logic INSTR_VALID_I,
   input wire logic [15:0] INSTR_I,
   input wire logic [7:0] ACCUM_I,
   input wire logic [3:0] BANK_SELECT_REGISTER_I,
   input wire logic EXT_SET_EN_I,
   input wire logic [7:0] OPERAND_I,
   output rmu_pkg::rmu_mem_req_t MEM_REQ_O,
   output rmu_pkg::rmu_prod_t PROD_O,
   output logic PROD_WR_O
);
   import rmu_pkg::*;

   // Shared by the decoder and take_q1 so the decoder and the take_q1 checks see one opcode test
   function automatic logic mul_taken(input logic v, input logic [15:0] w);
      return v && w[OPC_MSB:OPC_LSB] == OPC_MUL_FILE;
   endfunction

   function automatic rmu_mem_req_t resolve(input logic sel, input logic [7:0] f,
                                            input logic [3:0] bank, input logic ext);
      rmu_mem_req_t r;
      r.rd = 1'b1;
      if (sel) begin
         r.mode = RMU_ADDR_BANKED; // RQ6
         r.addr = {bank, f}; // RQ6
      end else if (ext && f <= IDX_MAX) begin
         // No offset arithmetic is done here or anywhere else in the core
         r.mode = RMU_ADDR_INDEXED; // RQ7
         r.addr = {4'h0, f}; // RQ7
      end else begin
         r.mode = RMU_ADDR_ACCESS; // RQ5
         r.addr = (f < ACC_SPLIT) ? {4'h0, f} : {ACC_HI_BANK, f}; // RQ5
      end
      return r;
   endfunction

   logic hit_ff, nxt_hit;
   logic [7:0] acc_ff, nxt_acc;
   logic [15:0] mul_ff, nxt_mul;
   rmu_mem_req_t req_ff, nxt_req;
   rmu_prod_t prod_ff, nxt_prod;
   logic wr_ff, nxt_wr;
   logic [7:0] op_seen_ff, nxt_op;
   logic take_q1;

   assign take_q1 = PHASE_I == 2'h0 && mul_taken(INSTR_VALID_I, INSTR_I);

   always_comb begin
      nxt_hit = hit_ff;
      nxt_acc = acc_ff;
      nxt_mul = mul_ff;
      nxt_req = req_ff;
      nxt_prod = prod_ff;
      nxt_wr = 1'b0;
      nxt_op = op_seen_ff;
      case (PHASE_I)
         2'h0: begin
            nxt_hit = mul_taken(INSTR_VALID_I, INSTR_I); // RQ1
            nxt_req = '0;
            if (nxt_hit) begin
               nxt_req = resolve(INSTR_I[SEL_BIT], INSTR_I[7:0], BANK_SELECT_REGISTER_I, EXT_SET_EN_I);
               nxt_acc = ACCUM_I; // RQ3
            end
         end
         2'h1: begin
            nxt_req.rd = 1'b0;
            nxt_op = OPERAND_I;
            if (hit_ff) begin
               nxt_mul = {8'h00, OPERAND_I}; // RQ8
            end
         end
         2'h2: begin
            if (hit_ff) begin
               // Both operands widened first so no product bit is lost
               nxt_mul = {8'h00, acc_ff} * {8'h00, mul_ff[7:0]}; // RQ1
            end
         end
         default: begin
            if (hit_ff) begin
               nxt_prod.high = mul_ff[15:8]; // RQ2
               nxt_prod.low = mul_ff[7:0]; // RQ2
               nxt_wr = 1'b1; // RQ8
            end
            nxt_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         hit_ff <= 1'b0;
         acc_ff <= 8'h00;
         mul_ff <= 16'h0000;
         req_ff <= '0;
         prod_ff <= {PROD_RST, PROD_RST};
         wr_ff <= 1'b0;
         op_seen_ff <= 8'h00;
      end else begin
         hit_ff <= nxt_hit;
         acc_ff <= nxt_acc;
         mul_ff <= nxt_mul;
         req_ff <= nxt_req;
         prod_ff <= nxt_prod;
         wr_ff <= nxt_wr;
         op_seen_ff <= nxt_op;
      end
   end

   // Block has no write path to memory or accumulator, so RQ3/RQ4 hold by construction
   assign MEM_REQ_O = req_ff;
   assign PROD_O = prod_ff;
   assign PROD_WR_O = wr_ff;

   chk_decode_hit: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ1
      (PHASE_I == 2'h0 && INSTR_VALID_I && INSTR_I[15:9] == 7'h01) |=> hit_ff && MEM_REQ_O.rd)
      else $error("multiply opcode not decoded");
   chk_no_false_hit: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ1
      (PHASE_I == 2'h0 && INSTR_I[15:9] != 7'h01) |=> !hit_ff)
      else $error("wrong opcode decoded as multiply");
   chk_product_value: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ2
      PROD_WR_O |-> {PROD_O.high, PROD_O.low} == {8'h00, acc_ff} * {8'h00, op_seen_ff})
      else $error("product pair value wrong");
   chk_pair_stable: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ3
      !PROD_WR_O |-> $stable(PROD_O))
      else $error("product pair changed without write");
   chk_access_bank: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ5
      (PHASE_I == 2'h0 && INSTR_VALID_I && INSTR_I[15:8] == 8'h02 && !EXT_SET_EN_I)
      |=> MEM_REQ_O.mode == RMU_ADDR_ACCESS)
      else $error("selector 0 did not use access bank");
   chk_banked: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ6
      (PHASE_I == 2'h0 && INSTR_VALID_I && INSTR_I[15:8] == 8'h03)
      |=> MEM_REQ_O.addr == {$past(BANK_SELECT_REGISTER_I), $past(INSTR_I[7:0])})
      else $error("banked address wrong");
   chk_indexed: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ7
      (PHASE_I == 2'h0 && INSTR_VALID_I && INSTR_I[15:8] == 8'h02 && EXT_SET_EN_I && INSTR_I[7:0] <= 8'h5f)
      |=> MEM_REQ_O.mode == RMU_ADDR_INDEXED)
      else $error("indexed mode not chosen");
   chk_one_cycle: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ8
      (PHASE_I == 2'h0 && INSTR_VALID_I && INSTR_I[15:9] == 7'h01) |-> ##4 PROD_WR_O)
      else $error("product not written at end of cycle");
   chk_wr_phase: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ8
      PROD_WR_O |-> $past(PHASE_I) == 2'h3)
      else $error("product written outside fourth phase");

   chk_rd_one_cycle: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ8
      MEM_REQ_O.rd |=> !MEM_REQ_O.rd)
      else $error("read strobe stood longer than one cycle");
   chk_wr_pulse: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ8
      PROD_WR_O |=> !PROD_WR_O)
      else $error("product write stood longer than one cycle");
   chk_operand_take: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ8
      (PHASE_I == 2'h1 && hit_ff) |=> mul_ff == {8'h00, $past(OPERAND_I)})
      else $error("operand not taken in second phase");
   chk_mul_phase: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ1
      (PHASE_I == 2'h2 && hit_ff)
      |=> mul_ff == {8'h00, $past(acc_ff)} * {8'h00, $past(mul_ff[7:0])})
      else $error("product not formed in third phase");
   chk_pair_split: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ2
      PROD_WR_O |-> {PROD_O.high, PROD_O.low} == $past(mul_ff))
      else $error("product halves not split high and low");
   chk_wr_only_hit: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ1
      PROD_WR_O |-> $past(hit_ff))
      else $error("product written without a decoded multiply");
   chk_refused_req: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ1
      (PHASE_I == 2'h0 && !take_q1) |=> MEM_REQ_O == '0)
      else $error("refused word left a memory request");
   chk_refused_wr: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ1
      (PHASE_I == 2'h0 && !take_q1) |-> ##4 !PROD_WR_O)
      else $error("refused word wrote the product pair");

   // Accumulator copy is private; the core register itself is never touched
   chk_acc_taken: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ3
      take_q1 |=> acc_ff == $past(ACCUM_I))
      else $error("accumulator not taken at decode");
   chk_acc_hold: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ3
      !take_q1 |=> $stable(acc_ff))
      else $error("accumulator copy changed outside decode");
   chk_addr_held: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ5
      PHASE_I != 2'h0 |=> $stable(MEM_REQ_O.addr) && $stable(MEM_REQ_O.mode))
      else $error("operand address moved inside the cycle");

   chk_access_low: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ5
      (take_q1 && !INSTR_I[SEL_BIT] && !EXT_SET_EN_I && INSTR_I[7:0] < ACC_SPLIT)
      |=> MEM_REQ_O.addr == {4'h0, $past(INSTR_I[7:0])})
      else $error("low access bank address wrong");
   chk_access_high: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ5
      (take_q1 && !INSTR_I[SEL_BIT] && INSTR_I[7:0] >= ACC_SPLIT)
      |=> MEM_REQ_O.addr == {ACC_HI_BANK, $past(INSTR_I[7:0])})
      else $error("high access bank address wrong");
   chk_banked_mode: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ6
      (take_q1 && INSTR_I[SEL_BIT]) |=> MEM_REQ_O.mode == RMU_ADDR_BANKED)
      else $error("selector 1 did not use bank select");
   chk_indexed_addr: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ7
      (take_q1 && !INSTR_I[SEL_BIT] && EXT_SET_EN_I && INSTR_I[7:0] <= IDX_MAX)
      |=> MEM_REQ_O.addr == {4'h0, $past(INSTR_I[7:0])})
      else $error("indexed offset address wrong");
   chk_idx_bound: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I) // RQ7
      (take_q1 && !INSTR_I[SEL_BIT] && EXT_SET_EN_I && INSTR_I[7:0] > IDX_MAX)
      |=> MEM_REQ_O.mode == RMU_ADDR_ACCESS)
      else $error("indexed mode used above its limit");

   cov_banked: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      PROD_WR_O && $past(MEM_REQ_O.mode, 3) == RMU_ADDR_BANKED);
   cov_indexed: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I) MEM_REQ_O.mode == RMU_ADDR_INDEXED);
   cov_zero: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I) PROD_WR_O && PROD_O == '0);
   cov_max: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I) PROD_WR_O && PROD_O == 16'hfe01);
   cov_refused: cover property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      PHASE_I == 2'h0 && INSTR_VALID_I && !take_q1);
endmodule // rmu_core

// [dv/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rmu_pkg::*;
   logic clk = 0, rst_n = 0, vld = 0, ext = 0;
   logic [1:0] ph = 0;
   logic [15:0] ins = 0, last_p = 0;
   logic [7:0] acc = 0, opd = 0;
   logic [3:0] bank = 0;
   rmu_mem_req_t req;
   rmu_prod_t prod;
   logic wr;
   int err_count = 0, checks = 0, cyc = 0;
   rmu_core u_dut (.CLOCK_I(clk), .RESETN_I(rst_n), .PHASE_I(ph), .INSTR_VALID_I(vld), .INSTR_I(ins),
      .ACCUM_I(acc), .BANK_SELECT_REGISTER_I(bank), .EXT_SET_EN_I(ext), .OPERAND_I(opd),
      .MEM_REQ_O(req), .PROD_O(prod), .PROD_WR_O(wr));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("Mismatches %0d, comparisons %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Whole run needs about 50 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         close_out();
      end
   end
   // One four-phase group; product of a refused word must not land
   task automatic op(input logic v, input logic [6:0] opc, input logic a, input logic [7:0] f,
      input logic [7:0] w, input logic [7:0] d);
      logic take;
      logic [11:0] ea;
      rmu_mode_t em;
      take = v && opc == OPC_MUL_FILE;
      if (a) begin
         em = RMU_ADDR_BANKED;
         ea = {bank, f};
      end else if (ext && f <= IDX_MAX) begin
         em = RMU_ADDR_INDEXED;
         ea = {4'h0, f};
      end else begin
         em = RMU_ADDR_ACCESS;
         ea = {(f < ACC_SPLIT) ? 4'h0 : ACC_HI_BANK, f};
      end
      ph = 2'h0; vld = v; ins = {opc, a, f}; acc = w;
      for (int i = 1; i < 5; i++) begin
         @(posedge clk); #5;
         ph = 2'(i); opd = d;
         if (i == 1) check(16'(req.rd), 16'(take));
         if (i == 1 && take) check(16'(req.mode), 16'(em));
         if (i == 1 && take) check(16'(req.addr), 16'(ea));
      end
      if (take) last_p = {8'h00, w} * {8'h00, d};
      check(16'(wr), 16'(take));
      check(prod, last_p);
      ph = 2'h0;
   endtask
   task automatic s_example;
      bank = 4'h3; ext = 0;
      op(1, OPC_MUL_FILE, 1, 8'h25, 8'hc4, 8'hb5);
      check(prod, 16'h8a94);
   endtask
   task automatic s_modes;
      op(1, OPC_MUL_FILE, 0, 8'h10, 8'h02, 8'h03);
      op(1, OPC_MUL_FILE, 0, 8'h80, 8'h11, 8'h10);
      ext = 1;
      op(1, OPC_MUL_FILE, 0, 8'h5f, 8'h07, 8'h09);
      op(1, OPC_MUL_FILE, 0, 8'h60, 8'h0a, 8'h0b);
      op(1, OPC_MUL_FILE, 1, 8'h5f, 8'h0c, 8'h0d);
   endtask
   task automatic s_edges;
      op(1, OPC_MUL_FILE, 1, 8'hff, 8'hff, 8'hff);
      check(prod, 16'hfe01);
      op(1, OPC_MUL_FILE, 1, 8'h00, 8'h00, 8'h37);
   endtask
   task automatic s_refuse;
      op(1, OPC_MUL_FILE, 1, 8'h01, 8'h05, 8'h06);
      op(1, 7'h03, 1, 8'h01, 8'h09, 8'h09);
      op(0, OPC_MUL_FILE, 1, 8'h01, 8'h08, 8'h08);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #5 rst_n = 1;
      check(prod, 16'(PROD_RST));
      check(16'(wr), 16'h0000);
      s_example();
      s_modes();
      s_edges();
      s_refuse();
      close_out();
   end
endmodule // tb
